// file: rtl/lpes_sequencer.sv
// low-power exit sequencer: supply requests, wake delays and resume selection
`timescale 1ns/1ps
module lpes_sequencer
   import lpes_pkg::*;
#(
   parameter int CPU_SUPPLY_US = CPU_SUPPLY_US_DEF,            // cpu supply delay, us
   parameter int CORE_RAMP_US  = CORE_RAMP_US_DEF,             // core ramp delay, us
   parameter int BOOT_STEP_US  = BOOT_STEP_US_DEF              // one boot delay step, us
) (
   input  wire logic                   clk_i,                  // 100 MHz clock
   input  wire logic                   rst_n_i,                // async reset, low
   input  wire logic                   enter_req_i,            // enter low power, pulse
   input  wire logic [2:0]             enter_mode_i,           // lpes_pkg::lpes_mode_e code
   input  wire logic                   wfe_entry_i,            // entry was by wfe
   input  wire logic                   discrete_regs_i,        // discrete regulators fitted
   input  wire logic [DLY_W-1:0]       lp_delay_i,             // low-power supply delay, us
   input  wire logic [BOOT_CODE_W-1:0] boot_supply_delay_i,    // boot supply delay code
   input  wire logic                   wake_i,                 // wake event, async level
   input  wire logic                   tamper_wake_i,          // tamper unit wake, async
   input  wire logic                   rtc_wake_i,             // rtc wake, async
   input  wire logic                   osc_ready_i,            // internal osc started, async
   output logic                        supply_on_request_o,    // supply on request pin
   output logic                        cpu_supply_request_o,   // cpu supply request pin
   output logic                        wake_notify_pin_o,      // battery wake notify pin
   output logic                        run_mode_o,             // run mode reached
   output logic                        boot_access_ok_o,       // boot interfaces powered
   output logic                        ram_retained_o,         // system ram kept valid
   output logic                        local_reset_o,          // processor reset, pulse
   output logic [1:0]                  resume_path_o,          // lpes_pkg::lpes_resume_e
   output logic [2:0]                  lp_mode_o               // recorded low-power mode
);
   import lpes_pkg::*;

   localparam logic [DLY_W-1:0] CORE_SEL_LOAD = DLY_W'(CORE_SELECT_TICKS);
   localparam logic [DLY_W-1:0] CPU_LOAD      = DLY_W'(CPU_SUPPLY_US);
   localparam logic [DLY_W-1:0] RAMP_LOAD     = DLY_W'(CORE_RAMP_US);
   localparam logic [TICK_W-1:0] TICK_LAST    = TICK_W'(TICK_CYCLES - 1);

   // larger of two delays, so one timer covers two concurrent waits
   function automatic logic [DLY_W-1:0] dly_max(input logic [DLY_W-1:0] a,
                                                input logic [DLY_W-1:0] b);
      dly_max = (a > b) ? a : b;
   endfunction

   // boot delay code to ticks; code 0 still gives one step
   function automatic logic [DLY_W-1:0] boot_load(input logic [BOOT_CODE_W-1:0] code);
      boot_load = DLY_W'((int'(code) + 1) * BOOT_STEP_US);
   endfunction

   typedef struct packed {
      logic [3:0]        s1;                                   // first sync stage
      logic [3:0]        s2;                                   // second sync stage
      logic [TICK_W-1:0] tick_cnt;                             // 1 us divider
      lpes_state_e       st;
      lpes_mode_e        mode;                                 // mode entered
      logic              wfe;                                  // entry was by wfe
      logic              supply_on;
      logic              cpu_req;
      logic              notify;
      logic              run;
      logic              boot_ok;
      logic              ram_ok;
      logic              local_rst;
      lpes_resume_e      resume;
      logic              tmr_start;
      logic [DLY_W-1:0]  tmr_load;
   } lpes_seq_s;

   lpes_seq_s q;                                               // registered state
   lpes_seq_s next_q;                                          // next state
   logic [1:0] rst_sync;                                       // reset release stages
   logic       rst_n;                                          // synchronised reset
   logic       tick;                                           // 1 us enable
   logic       tmr_done;                                       // delay elapsed
   logic       wake_s, tamper_s, rtc_s, osc_s;                 // synchronised pins

   // reset asserts at once, releases after two clean edges
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // only the second sync stage is read by logic
   assign wake_s   = q.s2[0];
   assign tamper_s = q.s2[1];
   assign rtc_s    = q.s2[2];
   assign osc_s    = q.s2[3];
   assign tick     = (q.tick_cnt == TICK_LAST);

   // one shared timer: delays never overlap except the cpu-off pair
   lpes_delay_timer #(
      .W       (DLY_W)
   ) u_timer (
      .clk_i   (clk_i),
      .rst_n   (rst_n),
      .start_i (q.tmr_start),
      .load_i  (q.tmr_load),
      .tick_i  (tick),
      .busy_o  (),
      .done_o  (tmr_done)
   );

   // next-state logic of the whole sequencer
   always_comb begin
      next_q           = q;
      next_q.s1        = {osc_ready_i, rtc_wake_i, tamper_wake_i, wake_i};
      next_q.s2        = q.s1;
      next_q.tick_cnt  = tick ? '0 : q.tick_cnt + TICK_W'(1);
      next_q.local_rst = 1'b0;
      next_q.tmr_start = 1'b0;
      unique case (q.st)
         // running: record the mode and drop the matching supply requests
         ST_RUN: begin
            if (enter_req_i) begin
               next_q.wfe = wfe_entry_i;
               case (enter_mode_i)
                  MODE_RET_STOP: begin
                     next_q.mode      = MODE_RET_STOP;
                     next_q.supply_on = 1'b0;
                     next_q.st        = ST_LOW;
                  end
                  MODE_RET_STOP_CPU: begin
                     next_q.mode      = MODE_RET_STOP_CPU;
                     next_q.supply_on = 1'b0;
                     next_q.cpu_req   = 1'b0;
                     next_q.st        = ST_LOW;
                  end
                  MODE_STANDBY: begin
                     next_q.mode      = MODE_STANDBY;
                     next_q.supply_on = 1'b0;
                     next_q.cpu_req   = 1'b0;
                     next_q.boot_ok   = 1'b0;
                     next_q.ram_ok    = 1'b0;
                     next_q.st        = ST_LOW;
                  end
                  MODE_BATTERY: begin
                     next_q.mode      = MODE_BATTERY;
                     next_q.supply_on = 1'b0;
                     next_q.cpu_req   = 1'b0;
                     next_q.boot_ok   = 1'b0;
                     next_q.ram_ok    = 1'b0;
                     next_q.st        = ST_BATT;
                  end
                  MODE_CORE_STOP: begin
                     next_q.mode = MODE_CORE_STOP;
                     next_q.st   = ST_LOW;
                  end
                  default: begin
                     next_q.st = ST_RUN;                        // unknown code ignored
                  end
               endcase
               if (next_q.st != ST_RUN) begin
                  next_q.run = 1'b0;
               end
            end
         end
         // asleep: the recorded mode picks the exit path
         ST_LOW: begin
            if (wake_s) begin
               unique case (q.mode)
                  MODE_RET_STOP: begin
                     next_q.supply_on = 1'b1;
                     next_q.tmr_start = 1'b1;
                     next_q.tmr_load  = CORE_SEL_LOAD;
                     next_q.st        = ST_CORE_SEL;
                  end
                  MODE_RET_STOP_CPU: begin
                     // a management chip follows supply_on, discrete parts need cpu_req
                     next_q.supply_on = 1'b1;
                     next_q.cpu_req   = 1'b1;
                     next_q.tmr_start = 1'b1;
                     next_q.tmr_load  = CORE_SEL_LOAD;
                     next_q.st        = ST_CORE_SEL;
                  end
                  MODE_STANDBY: begin
                     next_q.supply_on = 1'b1;
                     next_q.cpu_req   = 1'b1;
                     next_q.tmr_start = 1'b1;
                     next_q.tmr_load  = RAMP_LOAD;
                     next_q.st        = ST_RAMP;
                  end
                  MODE_CORE_STOP: begin
                     next_q.run    = 1'b1;
                     next_q.resume = q.wfe ? RES_AFTER_WFE : RES_IRQ;
                     next_q.st     = ST_RUN;
                  end
                  MODE_BATTERY: begin
                     next_q.st = ST_BATT;                       // not reached from here
                  end
                  default: begin
                     next_q.st = ST_RUN;
                  end
               endcase
            end
         end
         // core supply must be up before this delay ends
         ST_CORE_SEL: begin
            if (tmr_done) begin
               next_q.tmr_start = 1'b1;
               // cpu-off with discrete parts waits for both delays in parallel
               if (q.mode == MODE_RET_STOP_CPU && discrete_regs_i) begin
                  next_q.tmr_load = dly_max(lp_delay_i, CPU_LOAD);
               end else begin
                  next_q.tmr_load = lp_delay_i;
               end
               next_q.st = ST_SUPPLY;
            end
         end
         // other supplies settle within the programmed delay
         ST_SUPPLY: begin
            if (tmr_done) begin
               next_q.run = 1'b1;
               next_q.st  = ST_RUN;
               if (q.mode == MODE_RET_STOP_CPU) begin
                  next_q.ram_ok    = 1'b1;
                  next_q.local_rst = 1'b1;
                  next_q.resume    = RES_SCRATCH;
               end else begin
                  next_q.resume = q.wfe ? RES_AFTER_WFE : RES_IRQ;
               end
            end
         end
         // core ramp, then oscillator start, then boot supply delay
         ST_RAMP: begin
            if (tmr_done) begin
               next_q.st = ST_OSC;
            end
         end
         ST_OSC: begin
            if (osc_s) begin
               next_q.tmr_start = 1'b1;
               next_q.tmr_load  = boot_load(boot_supply_delay_i);
               next_q.st        = ST_BOOT;
            end
         end
         ST_BOOT: begin
            if (tmr_done) begin
               next_q.boot_ok   = 1'b1;
               next_q.run       = 1'b1;
               next_q.local_rst = 1'b1;
               next_q.resume    = RES_POR;
               next_q.st        = ST_RUN;
            end
         end
         // battery: only a fresh power reset leaves this state
         ST_BATT: begin
            if (tamper_s || rtc_s) begin
               next_q.notify = 1'b1;
            end
         end
      endcase
   end

   // state register; supplies requested on out of reset
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         q           <= '0;
         q.st        <= ST_RUN;
         q.mode      <= MODE_RET_STOP;
         q.resume    <= RES_POR;
         q.supply_on <= SUPPLY_ON_RST;
         q.cpu_req   <= CPU_REQ_RST;
         q.notify    <= NOTIFY_RST;
         q.run       <= 1'b1;
         q.boot_ok   <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign supply_on_request_o  = q.supply_on;
   assign cpu_supply_request_o = q.cpu_req;
   assign wake_notify_pin_o    = q.notify;
   assign run_mode_o           = q.run;
   assign boot_access_ok_o     = q.boot_ok;
   assign ram_retained_o       = q.ram_ok;
   assign local_reset_o        = q.local_rst;
   assign resume_path_o        = q.resume;
   assign lp_mode_o            = q.mode;

   // helper for assertions: cycles spent in the current state
   logic [31:0] dwell;
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dwell <= '0;
      end else if (next_q.st != q.st) begin
         dwell <= '0;
      end else begin
         dwell <= dwell + 32'h1;
      end
   end

   localparam int CORE_SEL_MIN_CYC = (CORE_SELECT_TICKS - 1) * TICK_CYCLES;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   sequence wake_in_s(lpes_mode_e m);
      q.st == ST_LOW && q.mode == m && wake_s;
   endsequence

   ret_wake_a: assert property (wake_in_s(MODE_RET_STOP) |=> supply_on_request_o
      && q.st == ST_CORE_SEL) else $error("supply request not raised");
   core_sel_dwell_a: assert property ($past(q.st) == ST_CORE_SEL && q.st == ST_SUPPLY
      |-> $past(dwell) >= CORE_SEL_MIN_CYC) else $error("core select cut short");
   cpu_wake_a: assert property (wake_in_s(MODE_RET_STOP_CPU) |=> cpu_supply_request_o
      && supply_on_request_o) else $error("cpu request not raised");
   run_entry_a: assert property ($rose(run_mode_o) |-> $past(q.st) inside
      {ST_SUPPLY, ST_BOOT, ST_LOW}) else $error("run entered early");
   local_rst_a: assert property (local_reset_o |-> run_mode_o && resume_path_o inside
      {RES_SCRATCH, RES_POR}) else $error("local reset without resume");
   standby_wake_a: assert property (wake_in_s(MODE_STANDBY) |=> supply_on_request_o
      && cpu_supply_request_o && !run_mode_o) else $error("standby requests");
   osc_wait_a: assert property (q.st == ST_OSC && !osc_s |=> q.st == ST_OSC
      && !boot_access_ok_o) else $error("oscillator wait skipped");
   boot_ok_a: assert property ($rose(boot_access_ok_o) |-> $past(q.st) == ST_BOOT
      && resume_path_o == RES_POR) else $error("boot access too soon");
   notify_a: assert property (q.st == ST_BATT && (tamper_s || rtc_s) |=> wake_notify_pin_o
      ##1 wake_notify_pin_o) else $error("notify pin not held");
   core_stop_a: assert property (wake_in_s(MODE_CORE_STOP) |=> run_mode_o
      && resume_path_o == ($past(q.wfe) ? RES_AFTER_WFE : RES_IRQ))
      else $error("core stop resume wrong");

endmodule

// file: include/lpes_pkg.sv
// constants, timing counts and encodings shared by the low-power exit sequencer
package lpes_pkg;

   // base clock and the 1 us tick that paces every delay
   localparam int CLK_PERIOD_NS = 10;                          // 100 MHz system clock
   localparam int TICK_NS       = 1000;                        // one delay tick is 1 us
   localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;     // clocks per tick
   localparam int TICK_W        = 7;                           // holds TICK_CYCLES-1

   // delay counters count ticks (microseconds)
   localparam int DLY_W          = 16;                         // up to about 65 ms
   localparam int CORE_SELECT_US = 234;                        // core select delay, us
   localparam int CORE_SELECT_TICKS = (CORE_SELECT_US * 1000) / TICK_NS;

   // defaults of the delays that the block leaves as parameters
   localparam int CPU_SUPPLY_US_DEF = 100;                     // cpu supply delay, us
   localparam int CORE_RAMP_US_DEF  = 100;                     // core ramp delay, us
   localparam int BOOT_STEP_US_DEF  = 1000;                    // one boot delay step, us
   localparam int BOOT_CODE_W       = 3;                       // boot supply delay code

   // reset values of the pin level requests
   localparam logic SUPPLY_ON_RST  = 1'b1;                     // supplies on out of reset
   localparam logic CPU_REQ_RST    = 1'b1;
   localparam logic NOTIFY_RST     = 1'b0;

   // low-power mode that was entered
   typedef enum logic [2:0] {
      MODE_RET_STOP     = 3'h0,                                // retention stop
      MODE_RET_STOP_CPU = 3'h1,                                // retention stop, cpu off
      MODE_STANDBY      = 3'h2,                                // standby
      MODE_BATTERY      = 3'h3,                                // battery mode
      MODE_CORE_STOP    = 3'h4                                 // core stop only
   } lpes_mode_e;

   // how the processor resumes
   typedef enum logic [1:0] {
      RES_IRQ      = 2'h0,                                     // interrupt handler
      RES_AFTER_WFE = 2'h1,                                    // instruction after wfe
      RES_SCRATCH  = 2'h2,                                     // jump to scratch address
      RES_POR      = 2'h3                                      // full power-on style boot
   } lpes_resume_e;

   // sequencer states
   typedef enum logic [2:0] {
      ST_RUN      = 3'h0,
      ST_LOW      = 3'h1,
      ST_CORE_SEL = 3'h2,
      ST_SUPPLY   = 3'h3,
      ST_RAMP     = 3'h4,
      ST_OSC      = 3'h5,
      ST_BOOT     = 3'h6,
      ST_BATT     = 3'h7
   } lpes_state_e;

endpackage

// file: rtl/lpes_delay_timer.sv
// tick-paced down counter used for every wake-up delay
`timescale 1ns/1ps
module lpes_delay_timer
   import lpes_pkg::*;
#(
   parameter int W = DLY_W                                     // counter width
) (
   input  wire logic         clk_i,                            // system clock
   input  wire logic         rst_n,                            // synchronised reset, low
   input  wire logic         start_i,                          // load and start, pulse
   input  wire logic [W-1:0] load_i,                           // delay in ticks
   input  wire logic         tick_i,                           // 1 us enable pulse
   output logic              busy_o,                           // counting
   output logic              done_o                            // elapsed, one-cycle pulse
);

   typedef struct packed {
      logic [W-1:0] cnt;                                       // ticks left
      logic         busy;
      logic         done;
   } lpes_tmr_s;

   lpes_tmr_s q;
   lpes_tmr_s next_q;

   // next state: a zero load still waits one tick so no delay is skipped
   always_comb begin
      next_q      = q;
      next_q.done = 1'b0;
      if (start_i) begin
         next_q.cnt  = (load_i == '0) ? W'(1) : load_i;
         next_q.busy = 1'b1;
      end else if (q.busy && tick_i) begin
         if (q.cnt == W'(1)) begin
            next_q.busy = 1'b0;
            next_q.done = 1'b1;
         end else begin
            next_q.cnt = q.cnt - W'(1);
         end
      end
   end

   // state register
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign busy_o = q.busy;
   assign done_o = q.done;

endmodule

// file: tb/lpes_regulator_model.sv
// behavioural regulator answering the supply request pins
`timescale 1ns/1ps
module lpes_regulator_model #(
   parameter int RAMP = 100                    // rise time, clocks; well under delays
) (
   input  wire logic clk_i,                    // system clock
   input  wire logic supply_on_request_i,      // core and other supplies wanted
   input  wire logic cpu_supply_request_i,     // cpu supply wanted
   input  wire logic wake_notify_i,            // battery wake notify pin
   output logic      core_good_o,              // core supply at run level
   output logic      cpu_good_o,               // cpu supply at run level
   output logic      restart_o                 // full power-up restart, pulse
);
   int   core_n = 0;                           // clocks since core request
   int   cpu_n  = 0;                           // clocks since cpu request
   logic note_q = 1'b0;                        // notify seen last clock
   // supplies drop at once on release, rise well inside the core select delay
   always @(posedge clk_i) begin
      core_n <= supply_on_request_i ? core_n + 1 : 0;
      cpu_n  <= cpu_supply_request_i ? cpu_n + 1 : 0;
      note_q <= wake_notify_i;
   end
   assign core_good_o = core_n >= RAMP;
   assign cpu_good_o  = cpu_n >= RAMP;
   assign restart_o   = wake_notify_i & ~note_q;
endmodule

// file: tb/lpes_sequencer_tb.sv
// self-checking bench for the low-power exit sequencer
`timescale 1ns/1ps
module lpes_sequencer_tb;
   import lpes_pkg::*;
   typedef struct packed {logic [1:0] res; logic ram; logic lrst; logic core;} lpes_note_s;
   logic clk, rst_n, ereq, wfe, disc, wake, tamper_unit, rtc, osc;  // bench-driven inputs
   logic [2:0] emode, bcode, lpm;              // mode, boot code, recorded mode
   logic [15:0] lpd;                           // low-power supply delay, us
   logic sreq, creq, notif, run, boot, ram, lrst, cg, pg, rstart;  // observed
   logic [1:0] res;                            // resume path
   lpes_note_s notes[$];                       // expected wake results
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic prev_run = 1'b1;
   localparam int CPU_US = 8;                  // cpu delay, us; above every lp delay used
   lpes_sequencer #(.CPU_SUPPLY_US(CPU_US), .CORE_RAMP_US(2), .BOOT_STEP_US(2))
      lpes_sequencer_inst (
      .clk_i(clk), .rst_n_i(rst_n), .enter_req_i(ereq), .enter_mode_i(emode), .wfe_entry_i(wfe),
      .discrete_regs_i(disc), .lp_delay_i(lpd), .boot_supply_delay_i(bcode), .wake_i(wake),
      .tamper_wake_i(tamper_unit), .rtc_wake_i(rtc), .osc_ready_i(osc), .supply_on_request_o(sreq),
      .cpu_supply_request_o(creq), .wake_notify_pin_o(notif), .run_mode_o(run),
      .boot_access_ok_o(boot), .ram_retained_o(ram), .local_reset_o(lrst),
      .resume_path_o(res), .lp_mode_o(lpm));
   lpes_regulator_model lpes_regulator_model_inst (.clk_i(clk), .supply_on_request_i(sreq),
      .cpu_supply_request_i(creq), .wake_notify_i(notif), .core_good_o(cg), .cpu_good_o(pg),
      .restart_o(rstart));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("compares %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // cut a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         miscompares++;
         wrap_up();
      end
   end
   // on each rise of run, compare against the oldest note
   always @(negedge clk) begin
      lpes_note_s n;
      prev_run <= rst_n ? run : 1'b1;
      if (rst_n && run === 1'b1 && prev_run === 1'b0) begin
         n = notes.size() ? notes.pop_front() : 5'h1F;
         check({6'h0, res}, {6'h0, n.res});
         check({5'h0, ram, lrst, boot}, {5'h0, n.ram, n.lrst, 1'b1});
         check({7'h0, n.core & cg & pg}, {7'h0, n.core});
      end
   end
   // enter a mode, wake it and time the way back to run
   task automatic lowp(input logic [2:0] m, input lpes_note_s n, input int lo);
      int t0;
      int k;
      ereq = 1'b1;
      emode = m;
      @(negedge clk);
      ereq = 1'b0;
      @(negedge clk);
      check({4'h0, run, lpm}, {5'h0, m});
      if (m == 3'h2) check({7'h0, boot}, 8'h0);
      osc = (m != 3'h2);
      repeat (20) @(negedge clk);
      notes.push_back(n);
      wake = 1'b1;
      t0 = cycles;
      if (m != 3'h4) begin
         repeat (6) @(negedge clk);
         check({6'h0, sreq, creq | (m == 3'h0)}, 8'h3);
      end
      if (m == 3'h2) repeat (294) @(negedge clk);
      osc = 1'b1;
      for (k = 0; k < 40000 && run !== 1'b1; k++) @(negedge clk);
      k = cycles - t0;
      // lo already allows for tick jitter; the rest is sync and load latency
      check({7'h0, k >= lo && k <= lo + 250}, 8'h1);
      wake = 1'b0;
      @(negedge clk);
   endtask
   initial begin
      int lp;
      {rst_n, ereq, emode, wfe, wake, tamper_unit, rtc, bcode} = '0;
      {disc, osc, lpd} = {2'b11, 16'h1};
      void'($urandom(32'h07C9));
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      for (int w = 0; w < 2; w++) begin
         wfe = w[0];
         lowp(3'h4, {w[1:0], 3'b000}, 0);
      end
      ereq = 1'b1;
      emode = 3'h5;
      @(negedge clk);
      ereq = 1'b0;
      repeat (2) @(negedge clk);
      check({7'h0, run}, 8'h1);
      wfe = 1'b0;
      lpd = 16'($urandom_range(1, 6));
      // first tick of each timed delay may come almost a whole tick early
      lp = CORE_SELECT_TICKS + int'(lpd) - 2;
      lowp(3'h0, {RES_IRQ, 3'b001}, lp * TICK_CYCLES);
      lpd = 16'($urandom_range(1, 6));
      disc = 1'($urandom_range(0, 1));
      lp = (disc && int'(lpd) < CPU_US) ? CPU_US : int'(lpd);
      lowp(3'h1, {RES_SCRATCH, 3'b111}, (CORE_SELECT_TICKS + lp - 2) * TICK_CYCLES);
      bcode = 3'($urandom_range(0, 7));                             // scaled margin
      lp = ((int'(bcode) + 1) * 2 - 1) * TICK_CYCLES;
      lowp(3'h2, {RES_POR, 3'b011}, 300 + lp);
      ereq = 1'b1;
      emode = 3'h3;
      @(negedge clk);
      ereq = 1'b0;
      tamper_unit = 1'b1;
      for (int k = 0; k < 50 && rstart !== 1'b1; k++) @(negedge clk);
      check({6'h0, notif, run}, 8'h2);
      rst_n = 1'b0;
      tamper_unit = 1'b0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      check({6'h0, notif, sreq}, 8'h1);
      check({4'h0, run, lpm}, 8'h08);
      wrap_up();
   end
endmodule
